/* hw/microport_pkg.sv */
// Purpose: Shared constants for the serial host port with program RAM bootload.
// Assumes: 8-bit data, 6-bit register addresses, 4096-byte program RAM.
// Notes:   Bit counts are values of the serial bit counter before its increment.

package microport_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int              ADDR_W            = 6;
  localparam logic [5:0]      BRC_ADDR          = 6'h3F;
  localparam logic [7:0]      BRC_RESET         = 8'h00;
  localparam int              LOAD_MODE_BIT_POS = 2;
  localparam int              EXEC_RAM_BIT_POS  = 3;
  localparam int              ADDR_TOP_BIT      = 5;

  // ****************************************************************
  // Command byte
  // ****************************************************************
  localparam logic            RW_WRITE          = 1'b0;
  localparam logic            RW_READ           = 1'b1;
  localparam int              CMD_RW_POS        = 6;

  // ****************************************************************
  // Serial bit counter
  // ****************************************************************
  localparam logic [4:0]      CNT_ZERO          = 5'h00;
  localparam logic [4:0]      CNT_STEP          = 5'h01;
  localparam logic [4:0]      CNT_ADDR_LAST     = 5'h06;
  localparam logic [4:0]      CNT_CMD_DONE      = 5'h08;
  localparam logic [4:0]      CNT_DATA_LAST     = 5'h0F;
  localparam logic [4:0]      CNT_MAX           = 5'h10;

  // ****************************************************************
  // Program RAM and signature
  // ****************************************************************
  localparam int              RAM_AW            = 12;
  localparam logic [12:0]     RAM_DEPTH         = 13'h1000;
  localparam logic [12:0]     FILL_ZERO         = 13'h0000;
  localparam logic [12:0]     FILL_STEP         = 13'h0001;
  localparam logic [7:0]      SIG_SEED          = 8'h00;
  localparam logic [7:0]      SIG_TAPS          = 8'hB8;
  localparam logic [7:0]      BYTE_ZERO         = 8'h00;

endpackage : microport_pkg

/* hw/serial_microport_bootload.sv */
// Purpose: Serial host port giving register access and write-only program RAM load.
// Assumes: Host serial clock slower than about 1/4 of clk; clk runs continuously.
// Notes:   Frame logic runs on the serial clock and is cleared while select is high; handoff registers reset only on nrst.

`timescale 1ns/100ps

module serial_microport_bootload (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Serial port pins
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       serial_io_primary_in,
  output logic            serial_io_primary_out,
  output logic            serial_io_primary_oe_n,
  input  wire logic       serial_in_secondary,
  // Device register access
  output logic [5:0]      dev_addr,
  output logic [7:0]      dev_wdata,
  output logic            dev_wr,
  output logic            dev_rd,
  input  wire logic [7:0] dev_rdata,
  // Program fetch
  input  wire logic [11:0] prog_rd_addr,
  output logic [7:0]      prog_rd_data,
  // Boot status
  output logic [7:0]      boot_ram_control,
  output logic [7:0]      load_signature
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [7:0] shift_in(input logic lsb, input logic [7:0] sh,
                                          input logic bit_in);
    shift_in = lsb ? {bit_in, sh[7:1]} : {sh[6:0], bit_in};
  endfunction : shift_in

  // After seven bits: read/write bit and address, packed as {rw, addr}
  function automatic logic [6:0] cmd_fields(input logic lsb, input logic [7:0] sh);
    cmd_fields = lsb ? {sh[1], sh[7:2]} : sh[6:0];
  endfunction : cmd_fields

  function automatic logic [7:0] misr_step(input logic [7:0] sig, input logic [7:0] din);
    misr_step = {sig[6:0], ^(sig & microport_pkg::SIG_TAPS)} ^ din;
  endfunction : misr_step

  // First bit of a byte on the wire, per bit order
  function automatic logic tx_first(input logic lsb, input logic [7:0] sh);
    tx_first = lsb ? sh[0] : sh[7];
  endfunction : tx_first

  // Byte left after one bit has gone out
  function automatic logic [7:0] tx_rest(input logic lsb, input logic [7:0] sh);
    tx_rest = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
  endfunction : tx_rest

  // ****************************************************************
  // Link side: mode detect and receive
  // ****************************************************************
  logic       lsb_mode;
  logic [7:0] rx_sh;
  logic [4:0] bit_cnt;
  logic       cmd_rw;
  logic [6:0] cmd_hold;
  logic       cmd_tgl;
  logic [7:0] wr_hold;
  logic       wr_tgl;
  logic [7:0] tx_sh;
  logic [7:0] rd_hold;

  wire        rx_bit  = lsb_mode ? serial_io_primary_in : serial_in_secondary;
  wire  [7:0] next_rx = shift_in(lsb_mode, rx_sh, rx_bit);
  wire  [6:0] next_cmd = cmd_fields(lsb_mode, next_rx);
  wire        addr_done = bit_cnt == microport_pkg::CNT_ADDR_LAST;
  wire        data_done = bit_cnt == microport_pkg::CNT_DATA_LAST;
  wire        is_write  = cmd_hold[microport_pkg::CMD_RW_POS] == microport_pkg::RW_WRITE;

  // Clock level at the select falling edge decides the timing mode
  always_ff @(negedge cs_n or negedge nrst) begin
    if (!nrst) begin
      lsb_mode <= 1'b0;
    end else begin
      lsb_mode <= sclk;
    end
  end

  // Edge count holds at sixteen so that late edges are ignored
  wire        cnt_full  = bit_cnt == microport_pkg::CNT_MAX;
  wire  [4:0] next_cnt  = cnt_full ? bit_cnt : bit_cnt + microport_pkg::CNT_STEP;

  // Select high ends the frame and clears the link state
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_sh <= microport_pkg::BYTE_ZERO;
    end else begin
      rx_sh <= next_rx;
    end
  end

  // Rising link edges seen since select fell
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= microport_pkg::CNT_ZERO;
    end else begin
      bit_cnt <= next_cnt;
    end
  end

  // Read/write bit of this frame, known after the seventh edge
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cmd_rw <= microport_pkg::RW_WRITE;
    end else if (addr_done) begin
      cmd_rw <= next_cmd[microport_pkg::CMD_RW_POS];
    end
  end

  // Command handoff stays stable until the next frame's seventh edge
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      cmd_hold <= {microport_pkg::RW_WRITE, microport_pkg::BRC_ADDR};
      cmd_tgl  <= 1'b0;
    end else if (addr_done) begin
      cmd_hold <= next_cmd;
      cmd_tgl  <= ~cmd_tgl;
    end
  end

  // Write data handoff, taken at the sixteenth edge of writes only
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      wr_hold <= microport_pkg::BYTE_ZERO;
      wr_tgl  <= 1'b0;
    end else if (data_done && is_write) begin
      wr_hold <= next_rx;
      wr_tgl  <= ~wr_tgl;
    end
  end

  // ****************************************************************
  // Link side: transmit
  // ****************************************************************
  wire tx_start = bit_cnt == microport_pkg::CNT_CMD_DONE && cmd_rw == microport_pkg::RW_READ;
  wire tx_stop  = bit_cnt == microport_pkg::CNT_MAX;
  wire       next_load_bit = tx_first(lsb_mode, rd_hold);
  wire [7:0] next_load_sh  = tx_rest(lsb_mode, rd_hold);
  wire       next_tx_bit   = tx_first(lsb_mode, tx_sh);
  wire [7:0] next_tx_sh    = tx_rest(lsb_mode, tx_sh);

  // Pin enable: on for the data phase of reads only
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      serial_io_primary_oe_n <= 1'b1;
    end else if (tx_stop) begin
      serial_io_primary_oe_n <= 1'b1;
    end else if (tx_start) begin
      serial_io_primary_oe_n <= 1'b0;
    end
  end

  // rd_hold is read here with no synchroniser: it settles in clk about six
  // cycles after the seventh edge, 1.5 link periods before this load, so a
  // link clock faster than about 40 ns period would send stale read data
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_sh                 <= microport_pkg::BYTE_ZERO;
      serial_io_primary_out <= 1'b0;
    end else if (tx_start) begin
      serial_io_primary_out <= next_load_bit;
      tx_sh                 <= next_load_sh;
    end else if (!serial_io_primary_oe_n && !tx_stop) begin
      serial_io_primary_out <= next_tx_bit;
      tx_sh                 <= next_tx_sh;
    end
  end

  // ****************************************************************
  // Crossing into clk
  // ****************************************************************
  logic [2:0] cmd_sync;
  logic [2:0] wr_sync;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_sync <= 3'h0;
      wr_sync  <= 3'h0;
    end else begin
      cmd_sync <= {cmd_sync[1:0], cmd_tgl};
      wr_sync  <= {wr_sync[1:0], wr_tgl};
    end
  end

  // Each toggle marks one handed-off word; the word changes on the same link
  // edge as its toggle and is stable by the time the toggle leaves the
  // synchroniser flops, so only the toggle needs synchronising
  wire cmd_ev = cmd_sync[2] ^ cmd_sync[1];
  wire wr_ev  = wr_sync[2] ^ wr_sync[1];

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic [12:0] fill_cnt;
  logic        rd_wait;
  logic [7:0]  program_ram [0:4095];

  wire [5:0] h_addr   = cmd_hold[5:0];
  wire       h_read   = cmd_hold[microport_pkg::CMD_RW_POS] == microport_pkg::RW_READ;
  wire       boot_on  = boot_ram_control[microport_pkg::LOAD_MODE_BIT_POS];
  wire       is_brc   = h_addr == microport_pkg::BRC_ADDR;
  wire       rd_local = is_brc || boot_on;
  wire       brc_sel  = is_brc || (boot_on && h_addr[microport_pkg::ADDR_TOP_BIT]);
  wire [7:0] local_rd = brc_sel ? boot_ram_control : load_signature;
  wire       rd_ev    = cmd_ev && h_read;
  wire       dev_rd_hit = rd_ev && !rd_local;
  wire       dev_wr_hit = wr_ev && !boot_on && !is_brc;
  wire       brc_wr   = wr_ev && is_brc;
  wire       fill_wr  = wr_ev && boot_on && !is_brc;
  wire       fill_ok  = fill_wr && (fill_cnt < microport_pkg::RAM_DEPTH);
  wire       load_clr = brc_wr && !wr_hold[microport_pkg::LOAD_MODE_BIT_POS];

  // ****************************************************************
  // Device register port and read data
  // ****************************************************************
  // Register address follows every command, read or write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dev_addr <= microport_pkg::BRC_ADDR;
    end else if (cmd_ev) begin
      dev_addr <= h_addr;
    end
  end

  // Write data moves only with a register write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dev_wdata <= microport_pkg::BYTE_ZERO;
    end else if (dev_wr_hit) begin
      dev_wdata <= wr_hold;
    end
  end

  // One-cycle strobes; rd_wait marks the cycle the register answers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dev_wr  <= 1'b0;
      dev_rd  <= 1'b0;
      rd_wait <= 1'b0;
    end else begin
      dev_wr  <= dev_wr_hit;
      dev_rd  <= dev_rd_hit;
      rd_wait <= dev_rd;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_hold <= microport_pkg::BYTE_ZERO;
    end else if (rd_ev && rd_local) begin
      rd_hold <= local_rd;
    end else if (rd_wait) begin
      rd_hold <= dev_rdata;
    end
  end

  // ****************************************************************
  // Boot control, fill counter and signature
  // ****************************************************************
  wire [7:0]  next_sig  = misr_step(load_signature, wr_hold);
  wire [12:0] next_fill = fill_cnt + microport_pkg::FILL_STEP;

  // Boot control takes any write to its address, in or out of load mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_ram_control <= microport_pkg::BRC_RESET;
    end else if (brc_wr) begin
      boot_ram_control <= wr_hold;
    end
  end

  // Fill writes never address boot control, so reseed and step never meet
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      load_signature <= microport_pkg::SIG_SEED;
      fill_cnt       <= microport_pkg::FILL_ZERO;
    end else if (load_clr) begin
      load_signature <= microport_pkg::SIG_SEED;
      fill_cnt       <= microport_pkg::FILL_ZERO;
    end else if (fill_ok) begin
      load_signature <= next_sig;
      fill_cnt       <= next_fill;
    end
  end

  // ****************************************************************
  // Program RAM: filled from the port, read only by the fetch side
  // ****************************************************************
  // No port path reads this array back; only the fetch side does, and a
  // full counter blocks the write so later fills leave it untouched
  always_ff @(posedge clk) begin
    if (fill_ok) begin
      program_ram[fill_cnt[microport_pkg::RAM_AW-1:0]] <= wr_hold;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_rd_data <= microport_pkg::BYTE_ZERO;
    end else begin
      prog_rd_data <= program_ram[prog_rd_addr];
    end
  end

endmodule : serial_microport_bootload

/* sim/microport_chk_asserts.sv */
// Purpose: Port-level checks for the serial host port.
// Assumes: Link logic is cleared while cs_n is high.
// Notes:   Bound to the design module at the foot of this file.
`timescale 1ns/100ps
module microport_chk (
  // Clocks and resets
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       sclk,
  input wire logic       cs_n,
  // Observed outputs
  input wire logic       serial_io_primary_out,
  input wire logic       serial_io_primary_oe_n,
  input wire logic [5:0] dev_addr,
  input wire logic       dev_wr,
  input wire logic       dev_rd,
  input wire logic [7:0] boot_ram_control,
  input wire logic [7:0] load_signature
);
  // Rising link edges seen since select fell
  logic [4:0] edges;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) edges <= 5'h00;
    else if (edges != 5'h1F) edges <= edges + 5'h01;
  end
  a_idle_hiz: assert property (@(posedge clk) disable iff (!nrst)
    cs_n |-> serial_io_primary_oe_n) else $error("data pin driven while deselected");
  a_wr_pulse: assert property (@(posedge clk) disable iff (!nrst)
    dev_wr |=> !dev_wr) else $error("register write longer than one cycle");
  a_rd_pulse: assert property (@(posedge clk) disable iff (!nrst)
    dev_rd |=> !dev_rd) else $error("register read longer than one cycle");
  a_dev_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (dev_wr || dev_rd) |-> !boot_ram_control[2] && dev_addr != 6'h3F)
    else $error("register access during load or to boot control");
  a_sig_reseed: assert property (@(posedge clk) disable iff (!nrst)
    $fell(boot_ram_control[2]) |-> ##[0:2] load_signature == 8'h00)
    else $error("signature not reseeded on leaving load");
  a_sig_hold: assert property (@(posedge clk) disable iff (!nrst)
    !boot_ram_control[2] [*4] |=> $stable(load_signature))
    else $error("signature moved outside load");
  a_drive_window: assert property (@(posedge sclk) disable iff (cs_n)
    !serial_io_primary_oe_n |-> edges >= 5'h08) else $error("pin driven in command phase");
  a_out_on_fall: assert property (@(posedge clk) disable iff (!nrst)
    $changed(serial_io_primary_out) && !serial_io_primary_oe_n |-> !sclk)
    else $error("output bit changed while link clock high");
endmodule : microport_chk

bind serial_microport_bootload microport_chk i_microport_chk (
  .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
  .serial_io_primary_out(serial_io_primary_out),
  .serial_io_primary_oe_n(serial_io_primary_oe_n), .dev_addr(dev_addr),
  .dev_wr(dev_wr), .dev_rd(dev_rd), .boot_ram_control(boot_ram_control),
  .load_signature(load_signature));

/* sim/host_port_model.sv */
// Purpose: Host controller driving two-byte frames on the link.
// Assumes: Link clock 64 ns period, stopped between frames.
// Notes:   A released pin shows a pattern that flips every cycle.
`timescale 1ns/100ps
module host_port_model (
  // Pattern clock
  input  wire logic clk,
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      pin,
  output logic      sec,
  input  wire logic out,
  input  wire logic oe_n
);
  logic drv;
  logic en;
  logic pat;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 1'b0;
    en = 1'b0;
    pat = 1'b0;
    sec = 1'b0;
  end
  always @(posedge clk) pat <= ~pat;
  assign pin = !oe_n ? out : (en ? drv : pat);
  task automatic xfer(input logic lsb, input logic rw, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic b;
    q = 8'h00;
    sclk = lsb;
    #32 cs_n = 1'b0;
    #32;
    for (int i = 0; i < 16; i++) begin
      sclk = 1'b0;
      if (i == 0) b = rw;
      else if (i < 7) b = a[lsb ? i - 1 : 6 - i];
      else if (i == 7) b = 1'($urandom);
      else b = d[lsb ? i - 8 : 15 - i];
      drv = b;
      en = lsb && !(rw && i > 7);
      sec = (lsb || (rw && i > 7)) ? 1'($urandom) : b;
      #32 sclk = 1'b1;
      if (rw && i > 7) q[lsb ? i - 8 : 15 - i] = pin;
      #32;
    end
    sclk = lsb;
    en = 1'b0;
    #32 cs_n = 1'b1;
    #200;
  endtask : xfer
endmodule : host_port_model

/* sim/tb.sv */
// Purpose: Self-checking bench for the serial host port.
// Assumes: Register file behind dev_* answers combinationally.
// Notes:   Expectations come from a queue model of the load.
`timescale 1ns/100ps
module tb;
  localparam int LB = microport_pkg::LOAD_MODE_BIT_POS;
  logic        clk;
  logic        nrst;
  logic        sclk, cs_n, pin, sec, out, oe_n, dev_wr, dev_rd;
  logic [5:0]  dev_addr, a;
  logic [7:0]  dev_wdata, dev_rdata, prog_rd_data, ctrl_q, sig_q, ctrl, sig;
  logic [11:0] prog_rd_addr;
  logic [7:0]  dev_mem [64];
  logic [7:0]  exp_reg [64];
  logic [7:0]  ram_q [$];
  int          miscompares, total_checks, cycles;
  serial_microport_bootload i_serial_microport_bootload (
    .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .serial_io_primary_in(pin),
    .serial_io_primary_out(out), .serial_io_primary_oe_n(oe_n), .serial_in_secondary(sec),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .prog_rd_addr(prog_rd_addr), .prog_rd_data(prog_rd_data),
    .boot_ram_control(ctrl_q), .load_signature(sig_q));
  host_port_model i_host_port_model (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .pin(pin), .sec(sec), .out(out), .oe_n(oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (dev_wr) dev_mem[dev_addr] <= dev_wdata;
  assign dev_rdata = dev_mem[dev_addr];
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic lsb, input logic [5:0] wa, input logic [7:0] d);
    logic [7:0] q;
    i_host_port_model.xfer(lsb, microport_pkg::RW_WRITE, wa, d, q);
    if (wa == microport_pkg::BRC_ADDR) begin
      ctrl = d;
      if (!d[LB]) begin
        sig = 8'h00;
        ram_q.delete();
      end
    end else if (ctrl[LB]) begin
      if (ram_q.size() < 4096) begin
        ram_q.push_back(d);
        sig = {sig[6:0], ^(sig & microport_pkg::SIG_TAPS)} ^ d;
      end
    end else begin
      exp_reg[wa] = d;
    end
  endtask : wr
  task automatic rd(input logic lsb, input logic [5:0] ra);
    logic [7:0] q;
    i_host_port_model.xfer(lsb, microport_pkg::RW_READ, ra, 8'h00, q);
    if (ctrl[LB]) chk(q, ra[5] ? ctrl : sig);
    else chk(q, ra == microport_pkg::BRC_ADDR ? ctrl : exp_reg[ra]);
  endtask : rd
  task automatic ram_chk(input int i);
    @(posedge clk);
    #1 prog_rd_addr = 12'(i);
    @(posedge clk);
    #1 chk(prog_rd_data, ram_q[i]);
  endtask : ram_chk
  initial begin
    nrst = 1'b0;
    prog_rd_addr = 12'h000;
    ctrl = 8'h00;
    sig = 8'h00;
    foreach (dev_mem[i]) begin
      dev_mem[i] = 8'h00;
      exp_reg[i] = 8'h00;
    end
    void'($urandom(55027));
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    #3;
    rd(1'b0, 6'h3F);
    rd(1'b1, 6'h3F);
    for (int k = 0; k < 8; k++) begin
      a = 6'($urandom_range(62));
      wr(k[0], a, 8'($urandom));
      rd(!k[0], a);
    end
    wr(1'b0, 6'h3F, 8'h04);
    for (int k = 0; k < 10; k++) begin
      wr(k[0], 6'($urandom_range(62)), 8'($urandom));
      if (k == 4) rd(1'b1, 6'h05);
      if (k == 6) rd(1'b0, 6'h25);
    end
    wr(1'b1, 6'h3F, 8'h04);
    rd(1'b0, 6'h1A);
    for (int i = 0; i < 10; i++) ram_chk(i);
    chk(sig_q, sig);
    wr(1'b0, 6'h3F, 8'h00);
    chk(sig_q, sig);
    rd(1'b1, 6'h05);
    wr(1'b1, 6'h3F, 8'h04);
    wr(1'b0, 6'h2A, 8'($urandom));
    ram_chk(0);
    chk(sig_q, sig);
    chk(ctrl_q, ctrl);
    tally_and_finish();
  end
endmodule : tb
